// *** src/fmc_defines.svh ***
`ifndef FMC_DEFINES_SVH
`define FMC_DEFINES_SVH

// register byte offsets
`define FMC_OFS_CTRL 8'h00
`define FMC_OFS_WINDOW 8'h04
`define FMC_OFS_LOW 8'h08
`define FMC_OFS_HIGH 8'h0C
`define FMC_OFS_VALUE 8'h10
`define FMC_OFS_STATUS 8'h14
`define FMC_OFS_IRQ_STS 8'h18
`define FMC_OFS_IRQ_MASK 8'h1C
`define FMC_OFS_COUNT 8'h20

// control field positions
`define FMC_CTRL_SW_GATE 0
`define FMC_CTRL_HW_EN 1
`define FMC_CTRL_DIR_INV 2
`define FMC_CTRL_ENCODER 3
`define FMC_CTRL_AVERAGED 4
`define FMC_CTRL_CHAR_LO 5
`define FMC_CTRL_CHAR_HI 6
`define FMC_CTRL_FSEL_LO 8
`define FMC_CTRL_FSEL_HI 10

// event bit positions (irq status and mask)
`define FMC_EV_GATE_OPEN 0
`define FMC_EV_GATE_CLOSE 1
`define FMC_EV_END_MEAS 2
`define FMC_EV_LOW 3
`define FMC_EV_HIGH 4

// reset values and ranges
`define FMC_WINDOW_MS_MIN 14'h000A
`define FMC_WINDOW_MS_MAX 14'h2710
`define FMC_WINDOW_MS_DEF 14'h0064
`define FMC_LOW_DEF 32'h0000_0000
`define FMC_HIGH_DEF 32'h0393_8700
`define FMC_FSEL_MAX 3'h5
`define FMC_MHZ_PER_HZ_MS 24'hF4240

// timing
`define FMC_CLK_PERIOD_NS 25
`define FMC_MS_NS 1000000
`define FMC_HALF_PERIOD_1KHZ_NS 500000

`endif

// *** src/fmc_pkg.sv ***
package fmc_pkg;

  typedef enum logic [2:0] {
    FMC_ST_IDLE = 3'b001,
    FMC_ST_DIV = 3'b010,
    FMC_ST_DONE = 3'b100
  } fmc_state_t;

  typedef enum logic [1:0] {
    FMC_CHAR_NONE = 2'h0,
    FMC_CHAR_OUTSIDE = 2'h1,
    FMC_CHAR_BELOW = 2'h2,
    FMC_CHAR_ABOVE = 2'h3
  } fmc_char_t;

endpackage : fmc_pkg

// *** src/fmc_top.sv ***
`timescale 1ns/100ps
`include "fmc_defines.svh"

module fmc_top
  import fmc_pkg::*;
#(
  parameter int MS_CYCLES = `FMC_MS_NS / `FMC_CLK_PERIOD_NS,
  parameter int HALF_1KHZ_CYCLES = `FMC_HALF_PERIOD_1KHZ_NS / `FMC_CLK_PERIOD_NS,
  parameter logic [31:0] HIGH_DEFAULT = `FMC_HIGH_DEF
)
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic track_a_in,
  input wire logic track_b_in,
  input wire logic hw_gate_in,
  output logic limit_out,
  output logic irq_out
);

  localparam int DW = 48;

  // minimum stable time of an input for the selected ceiling, rounded up
  function automatic logic [15:0] filt_cycles(input logic [2:0] sel);
    int khz;
    int c;
    khz = 1;
    unique case (sel)
      3'h0: khz = 60;
      3'h1: khz = 30;
      3'h2: khz = 10;
      3'h3: khz = 5;
      3'h4: khz = 2;
      default: khz = 1;
    endcase
    c = (HALF_1KHZ_CYCLES + khz - 1) / khz;
    if (c < 1)
    begin
      c = 1;
    end
    filt_cycles = c[15:0];
  endfunction : filt_cycles

  logic rst_meta_b_r;
  logic rst_sync_b_r;

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_b_r <= 1'b0;
      rst_sync_b_r <= 1'b0;
    end
    else
    begin
      rst_meta_b_r <= 1'b1;
      rst_sync_b_r <= rst_meta_b_r;
    end
  end

  // configuration and status registers
  logic [10:0] ctrl_r;
  logic [13:0] window_ms_r;
  logic [31:0] low_r;
  logic [31:0] high_r;
  logic [4:0] irq_sts_r;
  logic [4:0] irq_mask_r;
  logic [31:0] value_r;
  logic [23:0] last_count_r;
  logic below_r;
  logic above_r;
  logic dir_r;

  logic wr_en;
  logic [31:0] wd;
  logic [13:0] win_wd;
  logic [2:0] fsel_wd;
  logic addr_ok;

  assign wr_en = psel_in & penable_in & pready_out & pwrite_in;
  assign wd = pwdata_in;
  assign fsel_wd = (wd[`FMC_CTRL_FSEL_HI:`FMC_CTRL_FSEL_LO] > `FMC_FSEL_MAX) ?
                   `FMC_FSEL_MAX : wd[`FMC_CTRL_FSEL_HI:`FMC_CTRL_FSEL_LO];
  assign win_wd = (wd[31:0] < {18'h0, `FMC_WINDOW_MS_MIN}) ? `FMC_WINDOW_MS_MIN :
                  (wd[31:0] > {18'h0, `FMC_WINDOW_MS_MAX}) ? `FMC_WINDOW_MS_MAX : wd[13:0];

  always_comb
  begin
    unique case (paddr_in)
      `FMC_OFS_CTRL, `FMC_OFS_WINDOW, `FMC_OFS_LOW, `FMC_OFS_HIGH,
      `FMC_OFS_VALUE, `FMC_OFS_STATUS, `FMC_OFS_IRQ_STS, `FMC_OFS_IRQ_MASK,
      `FMC_OFS_COUNT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // window length is clamped so an out-of-range write cannot stall or skip windows
  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      ctrl_r <= 11'h000;
      window_ms_r <= `FMC_WINDOW_MS_DEF;
      low_r <= `FMC_LOW_DEF;
      high_r <= HIGH_DEFAULT;
      irq_mask_r <= 5'h00;
    end
    else if (wr_en)
    begin
      unique case (paddr_in)
        `FMC_OFS_CTRL: ctrl_r <= {fsel_wd, 1'b0, wd[6:0]};
        `FMC_OFS_WINDOW: window_ms_r <= win_wd;
        `FMC_OFS_LOW: low_r <= wd;
        `FMC_OFS_HIGH: high_r <= wd;
        `FMC_OFS_IRQ_MASK: irq_mask_r <= wd[4:0];
        default: ;
      endcase
    end
  end

  // reset default of the high limit may be tuned per variant
  logic [31:0] high_eff;
  assign high_eff = high_r;

  // input filters: a level must persist for half the ceiling period
  logic [2:0] raw;
  logic [2:0] filt_r;
  logic [2:0] filt_d_r;
  logic [15:0] stab_r [3];
  logic [15:0] stab_lim;

  assign raw = {hw_gate_in, track_b_in, track_a_in};
  assign stab_lim = filt_cycles(ctrl_r[`FMC_CTRL_FSEL_HI:`FMC_CTRL_FSEL_LO]);

  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      filt_r <= 3'h0;
      filt_d_r <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        stab_r[i] <= 16'h0000;
      end
    end
    else
    begin
      filt_d_r <= filt_r;
      for (int i = 0; i < 3; i++)
      begin
        if (raw[i] == filt_r[i])
        begin
          stab_r[i] <= 16'h0000;
        end
        else if (stab_r[i] + 16'h0001 >= stab_lim)
        begin
          filt_r[i] <= raw[i];
          stab_r[i] <= 16'h0000;
        end
        else
        begin
          stab_r[i] <= stab_r[i] + 16'h0001;
        end
      end
    end
  end

  logic a_rise;
  logic a_fall;
  logic b_eff;
  logic sw_gate;
  logic hw_rise;
  logic hw_fall;
  logic gate_open;
  logic count_edge;

  assign a_rise = filt_r[0] & ~filt_d_r[0];
  assign a_fall = ~filt_r[0] & filt_d_r[0];
  assign b_eff = filt_r[1] ^ ctrl_r[`FMC_CTRL_DIR_INV];
  assign sw_gate = ctrl_r[`FMC_CTRL_SW_GATE];
  assign hw_rise = filt_r[2] & ~filt_d_r[2];
  assign hw_fall = ~filt_r[2] & filt_d_r[2];
  assign gate_open = sw_gate & (~ctrl_r[`FMC_CTRL_HW_EN] | filt_r[2]);
  // encoder single evaluation: up on A rising, down on A falling, both with B low
  assign count_edge = ctrl_r[`FMC_CTRL_ENCODER] ? ((a_rise | a_fall) & ~b_eff) : a_rise;

  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      dir_r <= 1'b0;
    end
    else if (gate_open && count_edge)
    begin
      dir_r <= ctrl_r[`FMC_CTRL_ENCODER] ? a_fall : b_eff;
    end
  end

  // integration window
  logic [15:0] ms_cnt_r;
  logic [13:0] win_cnt_r;
  logic [23:0] pulse_cnt_r;
  logic [23:0] cnt_fin;
  logic win_end;

  // the edge of the closing cycle belongs to the window it closes, so every window is whole
  assign cnt_fin = pulse_cnt_r + {23'h000000, count_edge};

  assign win_end = gate_open && (ms_cnt_r == 16'(MS_CYCLES - 1)) &&
                   (win_cnt_r + 14'h0001 >= window_ms_r);

  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      ms_cnt_r <= 16'h0000;
      win_cnt_r <= 14'h0000;
      pulse_cnt_r <= 24'h000000;
    end
    else if (!gate_open)
    begin
      ms_cnt_r <= 16'h0000;
      win_cnt_r <= 14'h0000;
      pulse_cnt_r <= 24'h000000;
    end
    else if (win_end)
    begin
      ms_cnt_r <= 16'h0000;
      win_cnt_r <= 14'h0000;
      pulse_cnt_r <= 24'h000000;
    end
    else
    begin
      if (ms_cnt_r == 16'(MS_CYCLES - 1))
      begin
        ms_cnt_r <= 16'h0000;
        win_cnt_r <= win_cnt_r + 14'h0001;
      end
      else
      begin
        ms_cnt_r <= ms_cnt_r + 16'h0001;
      end
      if (count_edge)
      begin
        pulse_cnt_r <= pulse_cnt_r + 24'h000001;
      end
    end
  end

  // sequential divider; a window is far longer than the DW cycles it needs
  fmc_state_t state_r;
  logic [DW-1:0] quo_r;
  logic [32:0] rem_r;
  logic [31:0] dvs_r;
  logic [5:0] step_r;
  logic [31:0] empty_r;
  logic [31:0] last_meas_r;
  logic avg_idle_r;
  logic [32:0] rem_sh;
  logic averaged;

  assign averaged = ctrl_r[`FMC_CTRL_AVERAGED];
  assign rem_sh = {rem_r[31:0], quo_r[DW-1]};

  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      state_r <= FMC_ST_IDLE;
      quo_r <= '0;
      rem_r <= '0;
      dvs_r <= 32'h0000_0001;
      step_r <= 6'h00;
      empty_r <= 32'h0000_0000;
      last_count_r <= 24'h000000;
      avg_idle_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        FMC_ST_IDLE:
        begin
          if (win_end)
          begin
            last_count_r <= cnt_fin;
            rem_r <= '0;
            step_r <= 6'h00;
            state_r <= FMC_ST_DIV;
            avg_idle_r <= averaged && cnt_fin == 24'h000000;
            // the last value with edges is divided, not the previous quotient
            if (averaged && cnt_fin == 24'h000000)
            begin
              empty_r <= empty_r + 32'h0000_0001;
              quo_r <= {16'h0000, last_meas_r};
              dvs_r <= empty_r + 32'h0000_0001;
            end
            else
            begin
              empty_r <= 32'h0000_0000;
              quo_r <= 48'(cnt_fin * `FMC_MHZ_PER_HZ_MS);
              dvs_r <= {18'h0, window_ms_r};
            end
          end
        end
        FMC_ST_DIV:
        begin
          if (rem_sh >= {1'b0, dvs_r})
          begin
            rem_r <= rem_sh - {1'b0, dvs_r};
            quo_r <= {quo_r[DW-2:0], 1'b1};
          end
          else
          begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[DW-2:0], 1'b0};
          end
          step_r <= step_r + 6'h01;
          if (step_r == 6'(DW - 1))
          begin
            state_r <= FMC_ST_DONE;
          end
        end
        FMC_ST_DONE:
        begin
          state_r <= FMC_ST_IDLE;
        end
      endcase
    end
  end

  // result, limit flags and output switch
  logic done;
  logic q_below;
  logic q_above;
  logic out_nxt;

  assign done = state_r == FMC_ST_DONE;
  assign q_below = quo_r[31:0] < low_r;
  assign q_above = quo_r[31:0] > high_eff;

  always_comb
  begin
    unique case (fmc_char_t'(ctrl_r[`FMC_CTRL_CHAR_HI:`FMC_CTRL_CHAR_LO]))
      FMC_CHAR_NONE: out_nxt = 1'b0;
      FMC_CHAR_OUTSIDE: out_nxt = q_below | q_above;
      FMC_CHAR_BELOW: out_nxt = q_below;
      FMC_CHAR_ABOVE: out_nxt = q_above;
    endcase
  end

  // low limit is assumed below the high limit; if not, both flags may be set
  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      value_r <= 32'h0000_0000;
      last_meas_r <= 32'h0000_0000;
      below_r <= 1'b0;
      above_r <= 1'b0;
      limit_out <= 1'b0;
    end
    else if (done)
    begin
      value_r <= quo_r[31:0];
      if (!avg_idle_r)
      begin
        last_meas_r <= quo_r[31:0];
      end
      below_r <= q_below;
      above_r <= q_above;
      limit_out <= out_nxt;
    end
  end

  // interrupt status: hardware set wins over a write-one clear
  logic [4:0] ev;
  logic [4:0] clr;

  always_comb
  begin
    ev = 5'h00;
    ev[`FMC_EV_GATE_OPEN] = ctrl_r[`FMC_CTRL_HW_EN] & sw_gate & hw_rise;
    ev[`FMC_EV_GATE_CLOSE] = ctrl_r[`FMC_CTRL_HW_EN] & sw_gate & hw_fall;
    ev[`FMC_EV_END_MEAS] = done;
    ev[`FMC_EV_LOW] = done & q_below;
    ev[`FMC_EV_HIGH] = done & q_above;
  end

  assign clr = (wr_en && paddr_in == `FMC_OFS_IRQ_STS) ? wd[4:0] : 5'h00;

  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      irq_sts_r <= 5'h00;
      irq_out <= 1'b0;
    end
    else
    begin
      irq_sts_r <= (irq_sts_r & ~clr) | ev;
      irq_out <= |(((irq_sts_r & ~clr) | ev) & irq_mask_r);
    end
  end

  // apb slave: one wait-free access cycle, registered answer
  logic [31:0] rd_nxt;

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    unique case (paddr_in)
      `FMC_OFS_CTRL: rd_nxt = {21'h0, ctrl_r};
      `FMC_OFS_WINDOW: rd_nxt = {18'h0, window_ms_r};
      `FMC_OFS_LOW: rd_nxt = low_r;
      `FMC_OFS_HIGH: rd_nxt = high_eff;
      `FMC_OFS_VALUE: rd_nxt = value_r;
      `FMC_OFS_STATUS: rd_nxt = {27'h0, limit_out, dir_r, gate_open, above_r, below_r};
      `FMC_OFS_IRQ_STS: rd_nxt = {27'h0, irq_sts_r};
      `FMC_OFS_IRQ_MASK: rd_nxt = {27'h0, irq_mask_r};
      `FMC_OFS_COUNT: rd_nxt = {8'h0, last_count_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else if (psel_in && !penable_in)
    begin
      pready_out <= 1'b1;
      pslverr_out <= ~addr_ok;
      prdata_out <= pwrite_in ? 32'h0000_0000 : rd_nxt;
    end
    else
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

endmodule : fmc_top

// *** tb/fmc_monitor.sv ***
`timescale 1ns/100ps
module fmc_monitor (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic track_a_in,
  input wire logic track_b_in,
  input wire logic hw_gate_in,
  input wire logic limit_out,
  input wire logic irq_out
);
  logic [4:0] mask_r;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_setup ##0 (!pwrite_in && paddr_in == a);
  endsequence
  // shadow of the mask, so irq_out can be tied to what software enabled
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      mask_r <= 5'h00;
    else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h1C)
      mask_r <= pwdata_in[4:0];
  end
  property p_rdy_setup;
    s_setup |=> pready_out;
  endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
  property p_rdy_one;
    pready_out |=> !pready_out;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
  property p_err_unmap;
    s_setup ##0 (paddr_in > 8'h20) |=> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_err_unmap: assert property (p_err_unmap) else $error("unmapped access not refused");
  property p_err_map;
    s_setup ##0 (paddr_in <= 8'h20 && paddr_in[1:0] == 2'b00) |=> !pslverr_out;
  endproperty
  a_err_map: assert property (p_err_map) else $error("mapped access refused");
  property p_win_range;
    s_rd(8'h04) |=> prdata_out inside {[32'h0000000A:32'h00002710]};
  endproperty
  a_win_range: assert property (p_win_range) else $error("window out of range");
  property p_sts_lim;
    s_rd(8'h14) |=> prdata_out[4] == $past(limit_out) && prdata_out[31:5] == 27'h0;
  endproperty
  a_sts_lim: assert property (p_sts_lim) else $error("status output bit mismatch");
  property p_sts_excl;
    s_rd(8'h14) |=> !(prdata_out[0] && prdata_out[1]);
  endproperty
  a_sts_excl: assert property (p_sts_excl) else $error("both limit flags set");
  property p_irq_mask;
    (mask_r == 5'h00) [*2] |-> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
endmodule : fmc_monitor

// *** tb/fmc_pulse_src.sv ***
`timescale 1ns/100ps
module fmc_pulse_src (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic dir_in,
  input wire logic [7:0] half_in,
  output logic track_a_out,
  output logic track_b_out
);
  logic [7:0] cnt_r;
  assign track_b_out = dir_in;
  // a started pulse always completes, so stopping never leaves a runt
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_r <= 8'h00;
      track_a_out <= 1'b0;
    end
    else if (run_in || track_a_out)
    begin
      if (cnt_r >= half_in - 8'h01)
      begin
        cnt_r <= 8'h00;
        track_a_out <= !track_a_out;
      end
      else
        cnt_r <= cnt_r + 8'h01;
    end
    else
      cnt_r <= 8'h00;
  end
endmodule : fmc_pulse_src

// *** tb/fmc_bench.sv ***
`timescale 1ns/100ps
module fmc_bench;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, dir = 1'b0, hw = 1'b0, err;
  logic [7:0] paddr = 8'h00, half = 8'h04;
  logic [31:0] pwdata = 32'h0, rdata, prdata, vp;
  logic pready, pslverr, lim, irq, ta, tb;
  int n_errors = 0, cmp_count = 0;
  int per [5] = '{8, 10, 16, 20, 40};
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
  logic [31:0] re [5] = '{32'h0, 32'h64, 32'h0, 32'h03938700, 32'h0};
  localparam logic [31:0] V = 32'h000F4240;
  logic [31:0] lo_t [4] = '{32'h0, 32'h0, V, V + 1};
  logic [31:0] hi_t [4] = '{V - 1, V, V + 1, V + 2};
  fmc_top #(.MS_CYCLES(8), .HALF_1KHZ_CYCLES(60)) dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .track_a_in(ta), .track_b_in(tb), .hw_gate_in(hw), .limit_out(lim), .irq_out(irq));
  fmc_pulse_src src (.clk_in(mclk_in), .rst_b_in(rst_b_in), .run_in(run), .dir_in(dir),
    .half_in(half), .track_a_out(ta), .track_b_out(tb));
  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      chk("pready", 32'h1, 32'h0);
  endtask : apb
  // waits for the end-of-measurement event, then reads the value
  task automatic measure();
    int n;
    apb(1'b1, 8'h18, 32'hFF);
    repeat (2) @(posedge mclk_in);
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 2000)
      chk("measure end", 32'h1, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
  endtask : measure
  function automatic logic [31:0] vexp(input int cnt, input int win);
    return 32'(cnt * 1000000 / win);
  endfunction : vexp
  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    stop_test();
  end
  initial
  begin
    int win, p;
    logic a, b, e;
    void'($urandom(32'hF123));
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", re[i], rdata);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b0, 8'h04, 32'h0);
    chk("window min", 32'h0A, rdata);
    apb(1'b1, 8'h04, 32'h4E20);
    apb(1'b0, 8'h04, 32'h0);
    chk("window max", 32'h2710, rdata);
    apb(1'b1, 8'h1C, 32'h4);
    repeat (4)
    begin
      win = ($urandom % 2) ? 10 : 20;
      p = per[$urandom % 5];
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h04, 32'(win));
      half <= 8'(p / 2);
      run <= 1'b1;
      apb(1'b1, 8'h00, 32'h1);
      measure();
      chk("value", vexp(win * 8 / p, win), rdata);
      apb(1'b0, 8'h20, 32'h0);
      chk("count", 32'(win * 8 / p), rdata);
    end
    // close the gate so the first limit window starts afresh with the new length
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h0A);
    half <= 8'h04;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h0C, hi_t[i]);
      apb(1'b1, 8'h08, lo_t[i]);
      b = V < lo_t[i];
      a = V > hi_t[i];
      for (int ch = 0; ch < 4; ch++)
      begin
        apb(1'b1, 8'h00, 32'(1 + (ch << 5)));
        measure();
        e = (ch == 0) ? 1'b0 : (ch == 1) ? (a | b) : (ch == 2) ? b : a;
        chk("limit output", 32'(e), 32'(lim));
        apb(1'b0, 8'h14, 32'h0);
        chk("limit flags", 32'({a, b}), 32'(rdata[1:0]));
        apb(1'b0, 8'h18, 32'h0);
        chk("limit events", 32'({a, b}), 32'(rdata[4:3]));
      end
    end
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'h03938700);
    apb(1'b1, 8'h1C, 32'h0);
    repeat (120) @(posedge mclk_in);
    chk("masked irq", 32'h0, 32'(irq));
    apb(1'b1, 8'h1C, 32'h4);
    dir <= 1'b1;
    for (int inv = 0; inv < 2; inv++)
    begin
      apb(1'b1, 8'h00, 32'(1 + (inv << 2)));
      measure();
      apb(1'b0, 8'h14, 32'h0);
      chk("direction", 32'(inv == 0), 32'(rdata[3]));
    end
    dir <= 1'b0;
    apb(1'b1, 8'h00, 32'h9);
    repeat (2) measure();
    chk("encoder value", 2 * V, rdata);
    apb(1'b1, 8'h00, 32'h501);
    repeat (2) measure();
    chk("slow filter", 32'h0, rdata);
    apb(1'b1, 8'h00, 32'h11);
    repeat (2) measure();
    chk("averaged live", V, rdata);
    // stop inside the running window: it is the last one with edges, all later ones are empty
    run <= 1'b0;
    measure();
    vp = rdata;
    for (int k = 1; k < 4; k++)
    begin
      measure();
      chk("averaged idle", vp / k, rdata);
    end
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) measure();
    chk("direct idle", 32'h0, rdata);
    run <= 1'b1;
    apb(1'b1, 8'h1C, 32'h3);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h18, 32'hFF);
    repeat (200) @(posedge mclk_in);
    apb(1'b0, 8'h18, 32'h0);
    chk("gate shut", 32'h0, rdata);
    hw <= 1'b1;
    repeat (20) @(posedge mclk_in);
    apb(1'b0, 8'h18, 32'h0);
    chk("gate open event", 32'h1, rdata);
    chk("gate irq", 32'h1, 32'(irq));
    hw <= 1'b0;
    repeat (20) @(posedge mclk_in);
    apb(1'b0, 8'h18, 32'h0);
    chk("gate close event", 32'h3, rdata);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, 8'h00, i ? 32'h503 : 32'h2);
      apb(1'b1, 8'h18, 32'hFF);
      hw <= 1'b1;
      repeat (30) @(posedge mclk_in);
      hw <= 1'b0;
      repeat (70) @(posedge mclk_in);
      apb(1'b0, 8'h18, 32'h0);
      chk("gate ignored", 32'h0, rdata);
    end
    stop_test();
  end
endmodule : fmc_bench
bind fmc_top fmc_monitor u_mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .paddr_in(paddr_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .track_a_in(track_a_in), .track_b_in(track_b_in), .hw_gate_in(hw_gate_in),
  .limit_out(limit_out), .irq_out(irq_out));
